// File: inc/cprd_defines.vh
// constants for the calibration pattern readout block
`ifndef CPRD_DEFINES_VH
`define CPRD_DEFINES_VH
// command encodings on cmd_code (cs,ras,cas,we style, collapsed)
`define CPRD_CMD_NOP 3'h0
`define CPRD_CMD_READ 3'h1
`define CPRD_CMD_LOAD 3'h2
`define CPRD_CMD_WRITE 3'h3
`define CPRD_CMD_OTHER 3'h4
// bank address of the third mode register
`define CPRD_BA_MR3 3'h3
// third mode register field positions
`define CPRD_MR3_EN_BIT 2
`define CPRD_MR3_PAGE_HI 1
`define CPRD_MR3_PAGE_LO 0
`define CPRD_PAGE_CAL 2'h0
// first mode register burst field: 00 fixed 8, 01 on the fly, 10 chop
`define CPRD_BL_FIXED8 2'h0
`define CPRD_BL_OTF 2'h1
`define CPRD_BL_CHOP4 2'h2
// address bit positions
`define CPRD_A_NIBBLE 2
`define CPRD_A_CHOP 12
// pattern across an eight beat burst, beat 0 in bit 0
`define CPRD_PATTERN 8'haa
// reset values
`define CPRD_MR3_RST 3'h0
`define CPRD_RL_RST 5'h06
`endif

// File: logic/cprd_fifo.v
// small flop fifo holding read requests, pattern or normal
`timescale 1ns/1ps
`default_nettype none
module cprd_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // drain side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_q [0:DEPTH-1]; // storage words
    reg [AW-1:0] wr_q; // write index
    reg [AW-1:0] rd_q; // read index
    reg [AW:0] cnt_q; // fill level
    wire push;
    wire pop;
    integer i;
    assign in_ready = (cnt_q != DEPTH);
    assign out_valid = (cnt_q != 0);
    assign out_data = mem_q[rd_q];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    // --------------------------------------------------------
    // pointers and storage
    // --------------------------------------------------------
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_q[i] <= {WIDTH{1'b0}};
            end
        end else begin
            if (push) begin
                mem_q[wr_q] <= in_data;
                wr_q <= (wr_q == DEPTH - 1) ? {AW{1'b0}} : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == DEPTH - 1) ? {AW{1'b0}} : rd_q + 1'b1;
            end
            // simultaneous push and pop keeps level
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// File: logic/cprd_top.v
// calibration pattern readout path of the dram command decoder
// How it works
// [R1] enable bit 0 normal, 1 pattern reads
// [R2] page select 00 picks calibration pattern
// [R3] controller never programs reserved page codes
// [R4] controller loads only with banks idle
// [R5] every read goes to pattern register
// [R6] controller issues only reads while enabled
// [R7] reset still works in pattern mode
// [R8] prime lanes or all lanes carry pattern
// [R9] eight beat and chop, fixed or fly
// [R10] controller drives low address bits 00
// [R11] eight beat reads: bit2 zero, order 0-7
// [R12] chop: bit2 picks lower or upper nibble
// [R13] beat 0 is lsb, beat 7 msb
// [R14] ignore other address bits, a12 chop select
// [R15] pattern always alternates 0,1 across burst
// [R16] controller waits delays before pattern reads
// [R17] controller writes nothing while enabled
// [R18] data appears read latency after command; code drives it one cycle later
// [R19] back to back pattern reads allowed
// [R20] exit after recovery via load enable 0
// [R21] after exit reads and writes use array
// [R22] bank address 011 selects third register
`timescale 1ns/1ps
`default_nettype none
`include "cprd_defines.vh"
module cprd_top #(
    parameter DQ_W = 16,
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW = 2
) (
    // clock and reset
    input wire mclk,
    input wire reset_n,
    // command and address from the controller
    input wire cmd_valid,
    input wire [2:0] cmd_code,
    input wire [2:0] bank_addr,
    input wire [13:0] addr,
    // static configuration
    input wire [1:0] burst_mode,
    input wire [4:0] read_latency_total,
    input wire all_lanes,
    input wire wide_part,
    // array read data for normal reads
    input wire [DQ_W-1:0] array_data,
    // request queue back pressure
    output reg cmd_ready,
    // data lanes toward the pins
    output reg [DQ_W-1:0] dq_out,
    output reg dq_oe,
    // state seen by the rest of the device
    output reg pattern_mode,
    output reg [1:0] page_select,
    output reg reserved_page
);
    // -------------------------------------------------------------
    // state machine codes, one hot
    // -------------------------------------------------------------
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT = 3'b010;
    localparam ST_BURST = 3'b100;

    reg [2:0] mr3_q; // enable plus page select
    reg [2:0] st_q; // burst engine state
    reg [4:0] wait_q; // latency countdown
    reg [2:0] beat_q; // beat within burst
    reg [2:0] last_q; // final beat index
    reg pat_q; // current burst is pattern
    reg [8:0] head_q; // request being served
    wire is_load;
    wire is_read;
    wire q_valid;
    wire q_ready;
    wire fifo_in_ready;
    wire [8:0] q_data;
    wire [8:0] req;
    wire chop;
    reg [DQ_W-1:0] lanes;

    // choose chop from mode and a12
    function chop_sel;
        input [1:0] mode;
        input a12;
        begin
            if (mode == `CPRD_BL_CHOP4) begin
                chop_sel = 1'b1;
            end else if (mode == `CPRD_BL_OTF) begin
                chop_sel = ~a12; // low a12 chops
            end else begin
                chop_sel = 1'b0;
            end
        end
    endfunction

    assign is_load = cmd_valid && cmd_code == `CPRD_CMD_LOAD &&
        bank_addr == `CPRD_BA_MR3; // [R22]
    assign is_read = cmd_valid && cmd_code == `CPRD_CMD_READ;
    assign chop = chop_sel(burst_mode, addr[`CPRD_A_CHOP]); // [R9] [R14]
    // request word: pattern flag, chop, nibble, six zero pad bits
    // only bits 2 and 12 are kept for pattern reads // [R14]
    assign req = {mr3_q[`CPRD_MR3_EN_BIT], chop,
        addr[`CPRD_A_NIBBLE] & chop, 6'h00}; // [R5] [R11]

    // -------------------------------------------------------------
    // read request queue, lets back to back reads stack up
    // -------------------------------------------------------------
    cprd_fifo #(
        .WIDTH(9),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) u_fifo (
        .mclk(mclk),
        .reset_n(reset_n),
        .in_valid(is_read),
        .in_ready(fifo_in_ready),
        .in_data(req),
        .out_valid(q_valid),
        .out_ready(q_ready),
        .out_data(q_data)
    ); // [R19]
    assign q_ready = (st_q == ST_IDLE);

    // -------------------------------------------------------------
    // third mode register; async reset honoured in any mode
    // -------------------------------------------------------------
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            mr3_q <= `CPRD_MR3_RST; // [R7]
        end else if (is_load) begin
            // enable 0 leaves page bits ignored on exit // [R20] [R21]
            mr3_q <= addr[2:0]; // [R1]
        end
    end

    // -------------------------------------------------------------
    // lane driver: prime lanes only, or every lane
    // -------------------------------------------------------------
    always @* begin
        lanes = {DQ_W{1'b0}};
        if (all_lanes) begin
            lanes = {DQ_W{1'b1}}; // [R8]
        end else begin
            lanes[0] = 1'b1; // [R8]
            if (wide_part && DQ_W > 8) begin
                lanes[8] = 1'b1; // upper byte prime lane
            end
        end
    end

    // -------------------------------------------------------------
    // burst engine: latency wait, then beat out
    // -------------------------------------------------------------
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            st_q <= ST_IDLE;
            wait_q <= 5'h00;
            beat_q <= 3'h0;
            last_q <= 3'h0;
            pat_q <= 1'b0;
            head_q <= 9'h000;
            dq_out <= {DQ_W{1'b0}};
            dq_oe <= 1'b0;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    dq_oe <= 1'b0;
                    if (q_valid) begin
                        head_q <= q_data;
                        // queue pop costs one cycle of latency
                        wait_q <= (read_latency_total > 5'h01) ?
                            read_latency_total - 5'h02 : 5'h00; // [R18]
                        st_q <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (wait_q == 5'h00) begin
                        pat_q <= head_q[8];
                        // upper nibble starts at beat 4 // [R12]
                        beat_q <= head_q[6] ? 3'h4 : 3'h0;
                        last_q <= head_q[7] ?
                            (head_q[6] ? 3'h7 : 3'h3) : 3'h7; // [R11]
                        st_q <= ST_BURST;
                    end else begin
                        wait_q <= wait_q - 5'h01;
                    end
                end
                ST_BURST: begin
                    dq_oe <= 1'b1;
                    if (pat_q && mr3_q[1:0] == `CPRD_PAGE_CAL) begin
                        // beat n takes pattern bit n // [R13] [R15] [R2]
                        // mask to one bit: a bare shift would be true
                        // for every beat and smear the pattern
                        dq_out <= (((`CPRD_PATTERN >> beat_q) & 8'h01)
                            != 8'h00) ? lanes : {DQ_W{1'b0}};
                    end else begin
                        dq_out <= pat_q ? {DQ_W{1'b0}} : array_data;
                    end
                    beat_q <= beat_q + 3'h1;
                    if (beat_q == last_q) begin
                        st_q <= ST_IDLE;
                    end
                end
                default: begin
                    st_q <= ST_IDLE;
                end
            endcase
        end
    end

    // -------------------------------------------------------------
    // registered status outputs
    // -------------------------------------------------------------
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cmd_ready <= 1'b0;
            pattern_mode <= 1'b0;
            page_select <= 2'h0;
            reserved_page <= 1'b0;
        end else begin
            cmd_ready <= fifo_in_ready;
            pattern_mode <= mr3_q[`CPRD_MR3_EN_BIT]; // [R1]
            page_select <= mr3_q[1:0];
            // flags a controller slip, data stays low then // [R3]
            reserved_page <= mr3_q[2] && mr3_q[1:0] != `CPRD_PAGE_CAL;
        end
    end
endmodule
`default_nettype wire

// File: tb/cprd_sva.sv
// checker for the pattern readout block
`timescale 1ns/1ps
`default_nettype none
`include "cprd_defines.vh"
module cprd_sva (
    // clock and commands
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic cmd_valid,
    input wire logic [2:0] cmd_code,
    input wire logic [2:0] bank_addr,
    input wire logic [13:0] addr,
    // lanes and state
    input wire logic all_lanes,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe,
    input wire logic pattern_mode,
    input wire logic reserved_page
);
    // ----------------------------------------
    // helpers and properties
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic [3:0] run_q; // beats of the current burst
    wire pat = pattern_mode && !reserved_page; // lanes carry pattern
    // burst length counter, cleared in gaps
    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            run_q <= 4'h0;
        else
            run_q <= dq_oe ? run_q + 4'h1 : 4'h0;
    end
    sequence s_load3;
        cmd_valid && cmd_code == `CPRD_CMD_LOAD && bank_addr == 3'h3;
    endsequence
    sequence s_burst_end;
        dq_oe ##1 !dq_oe;
    endsequence
    chk_mode_bit: assert property (s_load3 |-> ##2
        pattern_mode == $past(addr[2], 2)) else $error("mode bit");
    chk_page_code: assert property (s_load3 |-> ##2
        reserved_page == ($past(addr[2], 2) && $past(addr[1:0], 2) != 2'h0))
        else $error("reserved flag");
    chk_other_bank: assert property (!$past(cmd_valid)
        && cmd_valid && cmd_code == `CPRD_CMD_LOAD && bank_addr != 3'h3
        |-> ##2 $stable(pattern_mode)) else $error("wrong bank load");
    chk_burst_len: assert property (s_burst_end |->
        run_q == 4'h4 || run_q == 4'h8) else $error("burst length");
    chk_first_beat: assert property ($rose(dq_oe) && pat |->
        !dq_out[0]) else $error("first beat not zero");
    chk_beats_alt: assert property (dq_oe && $past(dq_oe) && pat |->
        dq_out[0] != $past(dq_out[0])) else $error("pattern not alternating");
    chk_prime_lanes: assert property (dq_oe && pat && !all_lanes |->
        dq_out[7:1] == 7'h0 && dq_out[15:9] == 7'h0) else $error("lanes");
    chk_all_lanes: assert property (dq_oe && pat && all_lanes |->
        dq_out == {16{dq_out[0]}}) else $error("all lanes differ");
endmodule
bind cprd_top cprd_sva u_sva (.mclk(mclk), .reset_n(reset_n),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .bank_addr(bank_addr),
    .addr(addr), .all_lanes(all_lanes), .dq_out(dq_out), .dq_oe(dq_oe),
    .pattern_mode(pattern_mode), .reserved_page(reserved_page));
`default_nettype wire

// File: tb/cprd_ctrl.sv
// memory controller model issuing commands
`timescale 1ns/1ps
`default_nettype none
`include "cprd_defines.vh"
module cprd_ctrl #(
    parameter WAIT_CYC = 4
) (
    // command bus
    input wire logic mclk,
    output logic cmd_valid = 1'b0,
    output logic [2:0] cmd_code = 3'h0,
    output logic [2:0] bank_addr = 3'h0,
    output logic [13:0] addr = 14'h0
);
    // ----------------------------------------
    // command tasks, no writes or activates
    // ----------------------------------------
    task automatic issue(input logic [2:0] c, b, input logic [13:0] a);
        @(posedge mclk);
        cmd_valid <= 1'b1;
        cmd_code <= c;
        bank_addr <= b;
        addr <= a;
    endtask
    // released lines flip so stale values never look valid
    task automatic idle;
        @(posedge mclk);
        cmd_valid <= 1'b0;
        cmd_code <= `CPRD_CMD_NOP;
        bank_addr <= ~bank_addr;
        addr <= ~addr;
    endtask
    // banks stay idle; recovery and update delays around the load
    task automatic load(input logic en, input logic [1:0] pg);
        repeat (WAIT_CYC) @(posedge mclk);
        issue(`CPRD_CMD_LOAD, 3'h3, {11'h0, en, pg});
        idle();
        repeat (WAIT_CYC) @(posedge mclk);
    endtask
    // low bits 00, junk on the ignored bits
    task automatic read(input logic a2, a12);
        issue(`CPRD_CMD_READ, 3'($urandom),
            {1'($urandom), a12, 9'($urandom), a2, 2'h0});
    endtask
endmodule
`default_nettype wire

// File: tb/calibration_pattern_readout_tb.sv
// bench for the calibration pattern readout block
`timescale 1ns/1ps
`default_nettype none
`include "cprd_defines.vh"
module calibration_pattern_readout_tb;
    // ----------------------------------------
    // stimulus and scoreboard
    // ----------------------------------------
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic cmd_valid, cmd_ready, all_lanes, wide_part, dq_oe, pat_on;
    logic pattern_mode, reserved_page, saw_full;
    logic [1:0] burst_mode, page_select;
    logic [2:0] cmd_code, bank_addr;
    logic [4:0] rl;
    logic [13:0] addr;
    logic [15:0] array_data, dq_out;
    logic [15:0] exp_q[$]; // beats still owed
    int miscompares = 0;
    int checks_done = 0;
    cprd_top DUT (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .bank_addr(bank_addr), .addr(addr),
        .burst_mode(burst_mode), .read_latency_total(rl),
        .all_lanes(all_lanes), .wide_part(wide_part),
        .array_data(array_data), .cmd_ready(cmd_ready), .dq_out(dq_out),
        .dq_oe(dq_oe), .pattern_mode(pattern_mode),
        .page_select(page_select), .reserved_page(reserved_page));
    cprd_ctrl u_ctrl (.mclk(mclk), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .bank_addr(bank_addr), .addr(addr));
    initial forever #25 mclk = ~mclk;
    task automatic check(input string n, input logic [15:0] e, s);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    function automatic logic [15:0] st;
        return 16'({pattern_mode, page_select, reserved_page});
    endfunction
    function automatic logic [15:0] lanes(input logic b);
        return all_lanes ? {16{b}} : {7'h0, wide_part & b, 7'h0, b};
    endfunction
    // each beat takes the oldest note; an unowed beat meets x
    always @(negedge mclk)
        if (dq_oe === 1'b1)
            check("dq", exp_q.size() ? exp_q.pop_front() : 'x, dq_out);
    task automatic cfg(input logic [1:0] m);
        @(posedge mclk);
        burst_mode <= m;
        all_lanes <= 1'($urandom);
        wide_part <= 1'($urandom);
        rl <= 5'(2 + $urandom % 6);
        array_data <= 16'($urandom);
    endtask
    // w waits for room; without it the read goes back to back
    task automatic rd(input logic a2, a12, input bit w);
        int i;
        int n;
        logic [7:0] p;
        for (i = 0; w && i < 40; i++) begin
            @(posedge mclk);
            #1;
            if (cmd_ready === 1'b1)
                break;
            saw_full = 1'b1;
        end
        if (i == 40) begin
            miscompares++;
            final_report();
        end
        p = `CPRD_PATTERN >> (a2 ? 4 : 0);
        n = burst_mode == `CPRD_BL_FIXED8 || burst_mode == 1 && a12 ? 8 : 4;
        for (i = 0; i < n; i++)
            exp_q.push_back(pat_on ? lanes(p[i]) : array_data);
        u_ctrl.read(a2, a12);
    endtask
    task automatic fin(input bit lat);
        int n;
        u_ctrl.idle();
        for (n = 0; lat && n < 40 && dq_oe !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        if (lat)
            check("latency", 16'(rl) + 16'h1, 16'(n));
        for (n = 0; n < 300 && exp_q.size() != 0; n++)
            @(posedge mclk);
        check("beats left", 16'h0, 16'(exp_q.size()));
        @(posedge mclk);
    endtask
    initial begin
        int k;
        burst_mode = `CPRD_BL_FIXED8;
        rl = 5'h4;
        all_lanes = 1'b0;
        wide_part = 1'b1;
        array_data = 16'h0;
        pat_on = 1'b0;
        void'($urandom(32'h991c));
        repeat (12) @(posedge mclk);
        check("reset outs", 16'h0, dq_out | st() | 16'(dq_oe));
        reset_n <= 1'b1;
        cfg(`CPRD_BL_FIXED8);
        rd(1'b0, 1'b1, 1'b1);
        fin(1'b1);
        u_ctrl.load(1'b1, 2'h0);
        pat_on = 1'b1;
        check("mode on", 16'h8, st());
        u_ctrl.issue(`CPRD_CMD_LOAD, 3'h2, 14'h0);
        u_ctrl.idle();
        repeat (4) @(posedge mclk);
        check("other bank", 16'h8, st());
        $display("test mode load done");
        for (k = 0; k < 6; k++) begin
            cfg(k == 0 ? 2'h0 : k < 3 ? `CPRD_BL_CHOP4 : `CPRD_BL_OTF);
            rd(k == 2 || k == 4, k == 3, 1'b1);
            fin(1'b1);
            rd(k == 2 || k == 4, k == 3, 1'b1);
            rd(k == 1 || k == 4, k == 3, 1'b0);
            fin(1'b0);
        end
        $display("test pattern bursts done");
        cfg(`CPRD_BL_FIXED8);
        // long latency so the queue is sure to fill before it drains
        @(posedge mclk);
        rl <= 5'h10;
        saw_full = 1'b0;
        for (k = 0; k < 6; k++) begin
            rd(1'b0, 1'b1, 1'b1);
            u_ctrl.idle();
        end
        fin(1'b0);
        check("queue full", 16'h1, 16'(saw_full));
        u_ctrl.load(1'b0, 2'($urandom));
        pat_on = 1'b0;
        check("mode off", 16'h0, st() & 16'h8);
        rd(1'b0, 1'b1, 1'b1);
        fin(1'b1);
        u_ctrl.load(1'b1, 2'h3);
        check("reserved", 16'hf, st());
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        check("reset mode", 16'h0, st());
        reset_n <= 1'b1;
        rd(1'b0, 1'b1, 1'b1);
        fin(1'b1);
        $display("test exit and reset done");
        final_report();
    end
endmodule
`default_nettype wire
